//--- rtl/cbsr_defines.svh
// Offsets, field positions, reset values and pin map of the register bank.
`ifndef CBSR_DEFINES_SVH
`define CBSR_DEFINES_SVH
`define CBSR_OFS_OUTPUT_ENABLE_BITS      8'h00
`define CBSR_OFS_PLL_MODE_AMPLITUDE_CTRL 8'h01
`define CBSR_OFS_OUTPUT_SLEW_CTRL        8'h02
`define CBSR_OFS_FREQUENCY_SELECT_CTRL   8'h03
`define CBSR_OFS_RESERVED_ALL_ONES       8'h04
`define CBSR_OFS_REVISION_VENDOR_CODE    8'h05
`define CBSR_OFS_DEVICE_TYPE_CODE        8'h06
`define CBSR_OFS_READ_LENGTH_COUNT       8'h07
`define CBSR_REG_COUNT                   8'h08
`define CBSR_BIT_OUT0                    3'h1
`define CBSR_BIT_OUT1                    3'h3
`define CBSR_BIT_OUT2                    3'h5
`define CBSR_BIT_OUT3                    3'h6
`define CBSR_BIT_SELECT                  5
`define CBSR_BIT_CHOICE_HI               4
`define CBSR_BIT_CHOICE_LO               3
`define CBSR_BIT_READBACK_HI             7
`define CBSR_BIT_READBACK_LO             6
`define CBSR_BIT_AMP_HI                  1
`define CBSR_BIT_AMP_LO                  0
`define CBSR_BIT_FEEDBACK                0
`define CBSR_BIT_LEN_HI                  4
`define CBSR_RSV_OUTPUT_BYTES            8'h95
`define CBSR_RSV_MODE_BYTE               8'h04
`define CBSR_RSV_RATE_BYTE               8'hC6
`define CBSR_RSV_ALL_ONES                8'hFF
`define CBSR_RST_GATES                   4'hF
`define CBSR_RST_SPEEDS                  4'hF
`define CBSR_RST_SELECT                  1'b0
`define CBSR_RST_CHOICE                  2'h0
`define CBSR_RST_AMPLITUDE               2'h2
`define CBSR_RST_FEEDBACK                1'b1
`define CBSR_RST_LENGTH                  5'h08
`define CBSR_ADDR_LOW                    7'h6B
`define CBSR_ADDR_MID                    7'h6C
`define CBSR_ADDR_HIGH                   7'h6D
`define CBSR_STRAP_LOW                   2'h0
`define CBSR_STRAP_MID                   2'h1
`define CBSR_SLOT_ACK                    4'h8
`define CBSR_SLOT_LOAD                   4'h9
`define CBSR_PIN_W                       11
`define CBSR_PIN_INIT                    11'h003
`define CBSR_PIN_SCL                     0
`define CBSR_PIN_SDA                     1
`define CBSR_PIN_POWER                   2
`define CBSR_PIN_ADDR_LO                 3
`define CBSR_PIN_MODE_LO                 5
`define CBSR_PIN_GATE_LO                 7
`endif

//--- rtl/cbsr_pin_filter.sv
// Three-stage pin sampler that accepts a level once two stages agree.
`include "cbsr_defines.svh"
`default_nettype none
module cbsr_pin_filter (
  // Clock, reset and enable
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic ce_in,
  // Pins in, settled levels out
  cbsr_pin_if.filt  pin_bus
);
  localparam logic [`CBSR_PIN_W-1:0] INIT = `CBSR_PIN_INIT;
  genvar gi;
  for (gi = 0; gi < `CBSR_PIN_W; gi++)
  begin : g_pin
    logic [2:0] stage_reg;
    logic       level_reg;
    // Only the second stage reads the first, so metastability stays there.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
      if (!reset_n_in)
      begin
        stage_reg <= {3{INIT[gi]}};
        level_reg <= INIT[gi];
      end
      else if (ce_in)
      begin
        stage_reg <= {stage_reg[1:0], pin_bus.raw[gi]};
        if (stage_reg[1] == stage_reg[2])
          level_reg <= stage_reg[2];
      end
    end
    assign pin_bus.level[gi] = level_reg;
  end
endmodule : cbsr_pin_filter
`default_nettype wire

//--- rtl/cbsr_pin_if.sv
// Raw pin levels and their settled copies between filter and core.
`include "cbsr_defines.svh"
`default_nettype none
interface cbsr_pin_if;
  logic [`CBSR_PIN_W-1:0] raw;
  logic [`CBSR_PIN_W-1:0] level;
  modport filt (input raw, output level);
  modport core (output raw, input level);
endinterface : cbsr_pin_if
`default_nettype wire

//--- rtl/cbsr_pkg.sv
// Types shared by the register bank modules.
`default_nettype none
package cbsr_pkg;
  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_addr  = 3'b001,
    st_index = 3'b010,
    st_count = 3'b011,
    st_wdata = 3'b100,
    st_read  = 3'b101
  } cbsr_state_type;
  typedef logic [7:0] cbsr_byte_type;
endpackage : cbsr_pkg
`default_nettype wire

//--- rtl/cbsr_top.sv
// Serial management target and configuration registers of the buffer.
// Notes on behaviour
// - Block read opens: start, write address, index N; address and index acked.
// - Repeated start then read address follows; the read address is acked.
// - Read returns the byte count first, then bytes N through N+X-1.
// - Byte 0 bits 6,5,3,1 enable outputs 3,2,1,0; reset to one.
// - A cleared enable bit beats the enable pin and holds the output low.
// - Byte 1 bits 7:6 read back the strap mode captured at power good.
// - Byte 1 bit 5 picks strap mode (0) or software mode (1).
// - Software mode bits 4:3 reset to zero, act only when bit 5 set.
// - Byte 1 bits 1:0 pick output amplitude, reset value two.
// - Byte 2 bits 6,5,3,1 set per-output edge speed, reset to one.
// - Byte 3 bit 5 enables software rate choice, reset to zero.
// - Rate choice bits 4:3 reset to zero, act only when bit 5 set.
// - Byte 3 bit 0 sets feedback edge speed, reset to one.
// - Byte 4 is reserved and always reads all ones.
// - Byte 5 reads fixed revision code high, maker code low.
// - Byte 6 reads fixed two-bit type code and six-bit device code.
// - Byte 7 bits 4:0 set the read length, reset to eight.
// - Block write: address, index, count, count data bytes, each acked, stop.
// - Target address comes from the three-level address strap.
`include "cbsr_defines.svh"
`default_nettype none
module cbsr_top #(
  parameter logic [3:0] REVISION_CODE = 4'h2, // Arbitrary value.
  parameter logic [3:0] MAKER_CODE    = 4'h5, // Arbitrary value.
  parameter logic [1:0] TYPE_CODE     = 2'h2, // Arbitrary value.
  parameter logic [5:0] DEVICE_CODE   = 6'h0A // Arbitrary value.
) (
  // Clock, reset and enable
  input  wire logic       mclk_in,
  input  wire logic       reset_n_in,
  input  wire logic       ce_in,
  // Serial management pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out_out,
  output logic            sda_oe_out,
  // Power, strap and gate pins
  input  wire logic       power_good_down_n_in,
  input  wire logic [1:0] target_address_strap_in,
  input  wire logic [1:0] strap_loop_mode_in,
  input  wire logic [3:0] out_gate_n_in,
  // Controls to the clock path
  output logic      [3:0] out_run_out,
  output logic      [1:0] loop_mode_out,
  output logic      [1:0] amplitude_out,
  output logic      [3:0] out_edge_speed_out,
  output logic            feedback_edge_speed_out,
  output logic            rate_sw_enable_out,
  output logic      [1:0] rate_choice_out
);
  localparam logic [2:0] OUT_POS [4] = '{`CBSR_BIT_OUT0, `CBSR_BIT_OUT1,
                                        `CBSR_BIT_OUT2, `CBSR_BIT_OUT3};
  localparam logic [3:0] GATE_RST  = `CBSR_RST_GATES;
  localparam logic [3:0] SPEED_RST = `CBSR_RST_SPEEDS;

  cbsr_pin_if pins ();

  cbsr_pkg::cbsr_state_type state_reg;
  cbsr_pkg::cbsr_state_type state_next;
  logic [3:0]               cnt_reg;
  logic [3:0]               cnt_next;
  cbsr_pkg::cbsr_byte_type  sh_reg;
  cbsr_pkg::cbsr_byte_type  sh_next;
  cbsr_pkg::cbsr_byte_type  idx_reg;
  cbsr_pkg::cbsr_byte_type  idx_next;
  cbsr_pkg::cbsr_byte_type  left_reg;
  cbsr_pkg::cbsr_byte_type  left_next;
  logic                     first_reg;
  logic                     first_next;
  logic                     drive_reg;
  logic                     drive_next;
  logic                     wr_en;
  logic                     scl_q_reg;
  logic                     sda_q_reg;
  logic                     pg_q_reg;
  logic [6:0]               addr_reg;
  logic [1:0]               strap_mode_reg;
  logic                     select_reg;
  logic [1:0]               sw_mode_reg;
  logic [1:0]               amp_reg;
  logic                     rate_en_reg;
  logic [1:0]               rate_sel_reg;
  logic                     fb_reg;
  logic [4:0]               len_reg;
  logic [3:0]               out_run_reg;
  logic [1:0]               loop_mode_reg;
  logic [3:0]               gate_vec;
  logic [3:0]               speed_vec;
  cbsr_pkg::cbsr_byte_type  img [8];

  wire logic       scl_l;
  wire logic       sda_l;
  wire logic       pg_l;
  wire logic [1:0] addr_strap_l;
  wire logic [1:0] mode_strap_l;
  wire logic [3:0] gate_n_l;
  wire logic       scl_rise;
  wire logic       scl_fall;
  wire logic       start_ev;
  wire logic       stop_ev;
  wire logic       pg_rise;
  wire logic [6:0] addr_pick;
  wire logic       wr_b0;
  wire logic       wr_b1;
  wire logic       wr_b2;
  wire logic       wr_b3;
  wire logic       wr_b7;
  cbsr_pkg::cbsr_byte_type rd_byte;
  cbsr_pkg::cbsr_byte_type tx_byte;

  assign pins.raw = {out_gate_n_in, strap_loop_mode_in,
                     target_address_strap_in, power_good_down_n_in,
                     sda_in, scl_in};

  cbsr_pin_filter u_filter (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .pin_bus    (pins.filt)
  );

  assign scl_l        = pins.level[`CBSR_PIN_SCL];
  assign sda_l        = pins.level[`CBSR_PIN_SDA];
  assign pg_l         = pins.level[`CBSR_PIN_POWER];
  assign addr_strap_l = pins.level[`CBSR_PIN_ADDR_LO +: 2];
  assign mode_strap_l = pins.level[`CBSR_PIN_MODE_LO +: 2];
  assign gate_n_l     = pins.level[`CBSR_PIN_GATE_LO +: 4];

  // Bus events come from settled levels, so a glitch never fakes a start.
  assign scl_rise = scl_l & ~scl_q_reg;
  assign scl_fall = ~scl_l & scl_q_reg;
  assign start_ev = scl_l & scl_q_reg & sda_q_reg & ~sda_l;
  assign stop_ev  = scl_l & scl_q_reg & ~sda_q_reg & sda_l;
  assign pg_rise  = pg_l & ~pg_q_reg;

  assign addr_pick = (addr_strap_l == `CBSR_STRAP_LOW) ? `CBSR_ADDR_LOW :
                     (addr_strap_l == `CBSR_STRAP_MID) ? `CBSR_ADDR_MID :
                     `CBSR_ADDR_HIGH;

  assign wr_b0 = wr_en & (idx_reg == `CBSR_OFS_OUTPUT_ENABLE_BITS);
  assign wr_b1 = wr_en & (idx_reg == `CBSR_OFS_PLL_MODE_AMPLITUDE_CTRL);
  assign wr_b2 = wr_en & (idx_reg == `CBSR_OFS_OUTPUT_SLEW_CTRL);
  assign wr_b3 = wr_en & (idx_reg == `CBSR_OFS_FREQUENCY_SELECT_CTRL);
  assign wr_b7 = wr_en & (idx_reg == `CBSR_OFS_READ_LENGTH_COUNT);

  // Read images; reserved bits read as one except in the length byte.
  always_comb
  begin
    img[0] = `CBSR_RSV_OUTPUT_BYTES;
    img[2] = `CBSR_RSV_OUTPUT_BYTES;
    for (int i = 0; i < 4; i++)
    begin
      img[0][OUT_POS[i]] = gate_vec[i];
      img[2][OUT_POS[i]] = speed_vec[i];
    end
    img[1] = `CBSR_RSV_MODE_BYTE;
    img[1][`CBSR_BIT_READBACK_HI:`CBSR_BIT_READBACK_LO] = strap_mode_reg;
    img[1][`CBSR_BIT_SELECT] = select_reg;
    img[1][`CBSR_BIT_CHOICE_HI:`CBSR_BIT_CHOICE_LO] = sw_mode_reg;
    img[1][`CBSR_BIT_AMP_HI:`CBSR_BIT_AMP_LO] = amp_reg;
    img[3] = `CBSR_RSV_RATE_BYTE;
    img[3][`CBSR_BIT_SELECT] = rate_en_reg;
    img[3][`CBSR_BIT_CHOICE_HI:`CBSR_BIT_CHOICE_LO] = rate_sel_reg;
    img[3][`CBSR_BIT_FEEDBACK] = fb_reg;
    img[4] = `CBSR_RSV_ALL_ONES;
    img[5] = {REVISION_CODE, MAKER_CODE};
    img[6] = {TYPE_CODE, DEVICE_CODE};
    img[7] = {3'h0, len_reg};
  end

  // Indices past the map read as zero rather than aliasing.
  assign rd_byte = (idx_reg < `CBSR_REG_COUNT) ? img[idx_reg[2:0]] : 8'h00;
  assign tx_byte = first_reg ? {3'h0, len_reg} : rd_byte;

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    idx_next   = idx_reg;
    left_next  = left_reg;
    first_next = first_reg;
    drive_next = drive_reg;
    wr_en      = 1'b0;
    if (start_ev)
    begin
      state_next = cbsr_pkg::st_addr;
      cnt_next   = 4'h0;
      drive_next = 1'b0;
    end
    else if (stop_ev)
    begin
      state_next = cbsr_pkg::st_idle;
      cnt_next   = 4'h0;
      drive_next = 1'b0;
    end
    else if (state_reg == cbsr_pkg::st_read)
    begin
      if (scl_rise && cnt_reg < `CBSR_SLOT_ACK)
      begin
        cnt_next = cnt_reg + 4'h1;
        sh_next  = {sh_reg[6:0], 1'b1};
      end
      else if (scl_rise && cnt_reg == `CBSR_SLOT_ACK)
      begin
        if (sda_l)
          state_next = cbsr_pkg::st_idle;
        else
          cnt_next = `CBSR_SLOT_LOAD;
      end
      else if (scl_fall && cnt_reg < `CBSR_SLOT_ACK)
        drive_next = ~sh_reg[7];
      else if (scl_fall && cnt_reg == `CBSR_SLOT_ACK)
        drive_next = 1'b0;
      else if (scl_fall && cnt_reg == `CBSR_SLOT_LOAD)
      begin
        sh_next    = tx_byte;
        drive_next = ~tx_byte[7];
        cnt_next   = 4'h0;
        first_next = 1'b0;
        if (!first_reg)
          idx_next = idx_reg + 8'h01;
      end
    end
    else if (state_reg != cbsr_pkg::st_idle)
    begin
      if (scl_rise && cnt_reg < `CBSR_SLOT_ACK)
      begin
        sh_next  = {sh_reg[6:0], sda_l};
        cnt_next = cnt_reg + 4'h1;
      end
      else if (scl_fall && cnt_reg == `CBSR_SLOT_LOAD)
      begin
        drive_next = 1'b0;
        cnt_next   = 4'h0;
      end
      else if (scl_fall && cnt_reg == `CBSR_SLOT_ACK)
      begin
        cnt_next   = `CBSR_SLOT_LOAD;
        drive_next = 1'b1;
        case (state_reg)
          cbsr_pkg::st_addr:
          begin
            if (sh_reg[7:1] != addr_reg)
            begin
              state_next = cbsr_pkg::st_idle;
              drive_next = 1'b0;
            end
            else if (sh_reg[0])
            begin
              state_next = cbsr_pkg::st_read;
              first_next = 1'b1;
            end
            else
              state_next = cbsr_pkg::st_index;
          end
          cbsr_pkg::st_index:
          begin
            idx_next   = sh_reg;
            state_next = cbsr_pkg::st_count;
          end
          cbsr_pkg::st_count:
          begin
            left_next  = sh_reg;
            state_next = cbsr_pkg::st_wdata;
          end
          cbsr_pkg::st_wdata:
          begin
            // Bytes beyond the announced count are refused with no ack.
            if (left_reg != 8'h00)
            begin
              wr_en     = 1'b1;
              left_next = left_reg - 8'h01;
              idx_next  = idx_reg + 8'h01;
            end
            else
            begin
              state_next = cbsr_pkg::st_idle;
              drive_next = 1'b0;
            end
          end
          default:
          begin
            state_next = cbsr_pkg::st_idle;
            drive_next = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_reg <= cbsr_pkg::st_idle;
      cnt_reg   <= 4'h0;
      sh_reg    <= 8'h00;
      idx_reg   <= 8'h00;
      left_reg  <= 8'h00;
      first_reg <= 1'b0;
      drive_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      idx_reg   <= idx_next;
      left_reg  <= left_next;
      first_reg <= first_next;
      drive_reg <= drive_next;
    end
  end

  // Straps are caught at every power-good rise, not followed afterwards.
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      scl_q_reg      <= 1'b1;
      sda_q_reg      <= 1'b1;
      pg_q_reg       <= 1'b0;
      addr_reg       <= `CBSR_ADDR_LOW;
      strap_mode_reg <= 2'h0;
    end
    else if (ce_in)
    begin
      scl_q_reg <= scl_l;
      sda_q_reg <= sda_l;
      pg_q_reg  <= pg_l;
      if (pg_rise)
      begin
        addr_reg       <= addr_pick;
        strap_mode_reg <= mode_strap_l;
      end
    end
  end

  genvar gi;
  for (gi = 0; gi < 4; gi++)
  begin : g_out
    logic gate_reg;
    logic speed_reg;
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
      if (!reset_n_in)
      begin
        gate_reg  <= GATE_RST[gi];
        speed_reg <= SPEED_RST[gi];
      end
      else if (ce_in)
      begin
        if (wr_b0)
          gate_reg <= sh_reg[OUT_POS[gi]];
        if (wr_b2)
          speed_reg <= sh_reg[OUT_POS[gi]];
      end
    end
    assign gate_vec[gi]  = gate_reg;
    assign speed_vec[gi] = speed_reg;
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      select_reg   <= `CBSR_RST_SELECT;
      sw_mode_reg  <= `CBSR_RST_CHOICE;
      amp_reg      <= `CBSR_RST_AMPLITUDE;
      rate_en_reg  <= `CBSR_RST_SELECT;
      rate_sel_reg <= `CBSR_RST_CHOICE;
      fb_reg       <= `CBSR_RST_FEEDBACK;
      len_reg      <= `CBSR_RST_LENGTH;
    end
    else if (ce_in)
    begin
      if (wr_b1)
      begin
        select_reg  <= sh_reg[`CBSR_BIT_SELECT];
        sw_mode_reg <= sh_reg[`CBSR_BIT_CHOICE_HI:`CBSR_BIT_CHOICE_LO];
        amp_reg     <= sh_reg[`CBSR_BIT_AMP_HI:`CBSR_BIT_AMP_LO];
      end
      if (wr_b3)
      begin
        rate_en_reg  <= sh_reg[`CBSR_BIT_SELECT];
        rate_sel_reg <= sh_reg[`CBSR_BIT_CHOICE_HI:`CBSR_BIT_CHOICE_LO];
        fb_reg       <= sh_reg[`CBSR_BIT_FEEDBACK];
      end
      if (wr_b7)
        len_reg <= sh_reg[`CBSR_BIT_LEN_HI:0];
    end
  end

  // Controls are registered so the analog side never sees decode glitches.
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      out_run_reg        <= 4'h0;
      loop_mode_reg      <= 2'h0;
      amplitude_out      <= `CBSR_RST_AMPLITUDE;
      out_edge_speed_out <= `CBSR_RST_SPEEDS;
      feedback_edge_speed_out <= `CBSR_RST_FEEDBACK;
      rate_sw_enable_out <= `CBSR_RST_SELECT;
      rate_choice_out    <= `CBSR_RST_CHOICE;
    end
    else if (ce_in)
    begin
      out_run_reg   <= {4{pg_l}} & gate_vec & ~gate_n_l;
      loop_mode_reg <= select_reg ? sw_mode_reg : strap_mode_reg;
      amplitude_out <= amp_reg;
      out_edge_speed_out      <= speed_vec;
      feedback_edge_speed_out <= fb_reg;
      rate_sw_enable_out      <= rate_en_reg;
      rate_choice_out <= rate_en_reg ? rate_sel_reg : 2'h0;
    end
  end

  // Open-drain: the pin is only ever pulled low, never driven high.
  assign sda_out_out   = 1'b0;
  assign sda_oe_out    = drive_reg;
  assign out_run_out   = out_run_reg;
  assign loop_mode_out = loop_mode_reg;
endmodule : cbsr_top
`default_nettype wire

//--- tb/cbsr_checker.sv
// Bound checker on the serial target pins and the control outputs.
`default_nettype none
module cbsr_checker (
  // Clock and reset
  input wire logic       mclk_in,
  input wire logic       reset_n_in,
  // Serial pins
  input wire logic       scl_in,
  input wire logic       sda_oe_out,
  // Power, gate pins and controls
  input wire logic       power_good_down_n_in,
  input wire logic [3:0] out_gate_n_in,
  input wire logic [3:0] out_run_out,
  input wire logic [1:0] amplitude_out,
  input wire logic [3:0] out_edge_speed_out,
  input wire logic       feedback_edge_speed_out,
  input wire logic       rate_sw_enable_out,
  input wire logic [1:0] rate_choice_out
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  property p_reset_out;
    $rose(reset_n_in) |-> amplitude_out == 2'h2 && !sda_oe_out
      && out_edge_speed_out == 4'hF && feedback_edge_speed_out == 1'b1
      && rate_sw_enable_out == 1'b0;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("control outputs wrong after reset");
  // Six cycles cover the three-stage pin filter and the output register.
  property p_run_off;
    !power_good_down_n_in [*6] |-> out_run_out == 4'h0;
  endproperty
  a_run_off: assert property (p_run_off)
    else $error("output runs while power is down");
  property p_run_pg;
    out_run_out != 4'h0 |-> $past(power_good_down_n_in, 5);
  endproperty
  a_run_pg: assert property (p_run_pg)
    else $error("output ran without power good");
  property p_gate_pin;
    $stable(out_gate_n_in) [*6] |-> (out_run_out & out_gate_n_in) == 4'h0;
  endproperty
  a_gate_pin: assert property (p_gate_pin)
    else $error("output runs with its gate pin high");
  property p_rate_off;
    !rate_sw_enable_out |-> rate_choice_out == 2'h0;
  endproperty
  a_rate_off: assert property (p_rate_off)
    else $error("rate choice passed while disabled");
  property p_oe_hold;
    scl_in && $past(scl_in) |-> $stable(sda_oe_out);
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("data line changed while clock high");
  property p_oe_rise;
    $rose(sda_oe_out) |-> !scl_in && !$past(scl_in, 3);
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("drive began too close to clock fall");
  property p_oe_fall;
    $fell(sda_oe_out) |-> !scl_in && !$past(scl_in, 3);
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("release came too close to clock fall");
  c_drive: cover property ($rose(sda_oe_out));
  c_rate: cover property (rate_sw_enable_out);
  c_run: cover property (out_run_out != 4'h0);
endmodule : cbsr_checker
bind cbsr_top cbsr_checker cbsr_checker_i (
  .mclk_in, .reset_n_in, .scl_in, .sda_oe_out, .power_good_down_n_in,
  .out_gate_n_in, .out_run_out, .amplitude_out, .out_edge_speed_out,
  .feedback_edge_speed_out, .rate_sw_enable_out, .rate_choice_out);
`default_nettype wire

//--- tb/cbsr_host_model.sv
// Bus host model that frames block writes and reads on the pins.
`default_nettype none
module cbsr_host_model (
  // Clock and bus
  input  wire logic mclk_in,
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_pull_out
);
  timeunit 1ns / 1ps;
  logic [7:0] seen;
  event       seen_ev;
  initial
  begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : hold
  // Ten cycles a phase leave margin over the filter and drive delays.
  task automatic bit_io(input logic b, output logic r);
    sda_pull_out = ~b;
    hold(10);
    scl_out = 1'b1;
    hold(5);
    r = sda_in;
    hold(5);
    scl_out = 1'b0;
    hold(2);
  endtask : bit_io
  task automatic start();
    sda_pull_out = 1'b0;
    hold(10);
    scl_out = 1'b1;
    hold(10);
    sda_pull_out = 1'b1;
    hold(10);
    scl_out = 1'b0;
    hold(2);
  endtask : start
  task automatic stop();
    sda_pull_out = 1'b1;
    hold(10);
    scl_out = 1'b1;
    hold(10);
    sda_pull_out = 1'b0;
    hold(10);
  endtask : stop
  task automatic send(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    seen = {7'h00, ~r};
    -> seen_ev;
  endtask : send
  task automatic fetch(input logic last);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      seen[i] = r;
    end
    bit_io(last, r);
    -> seen_ev;
  endtask : fetch
endmodule : cbsr_host_model
`default_nettype wire

//--- tb/cbsr_top_tb.sv
// Self-checking bench: block transfers against a shadow of the bank.
`default_nettype none
module cbsr_top_tb;
  timeunit 1ns / 1ps;
  logic       mclk_in, reset_n_in, scl, pull, sda_oe, pg, fb_spd, rate_en, ce;
  logic [1:0] addr_strap, mode_strap, loop_mode, amp, rate, rnd;
  logic [3:0] gate_n, run, edge_spd;
  logic [6:0] dev_addr;
  logic [7:0] shadow [8];
  logic [7:0] wmask [8] = '{8'h6A, 8'h3B, 8'h6A, 8'h39, 8'h00, 8'h00,
                            8'h00, 8'h1F};
  logic [7:0] exp_q [$];
  int         n_fail = 0;
  int         n_tests = 0;
  wire        sda = ~(pull | sda_oe);
  cbsr_top cbsr_top_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .ce_in(ce), .scl_in(scl), .sda_in(sda), .sda_out_out(),
    .sda_oe_out(sda_oe), .power_good_down_n_in(pg),
    .target_address_strap_in(addr_strap), .strap_loop_mode_in(mode_strap),
    .out_gate_n_in(gate_n), .out_run_out(run), .loop_mode_out(loop_mode),
    .amplitude_out(amp), .out_edge_speed_out(edge_spd),
    .feedback_edge_speed_out(fb_spd), .rate_sw_enable_out(rate_en),
    .rate_choice_out(rate));
  cbsr_host_model cbsr_host_model_i (.mclk_in(mclk_in), .sda_in(sda),
    .scl_out(scl), .sda_pull_out(pull));
  task automatic wrap_up();
    if (exp_q.size() != 0)
      n_fail++;
    $display("TB: tests %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic tally(input logic ok, input logic [15:0] e, g);
    n_tests++;
    if (!ok)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, e, g);
    end
  endtask : tally
  task automatic check_bus(input logic [7:0] e, g);
    tally(g === e, {8'h00, e}, {8'h00, g});
  endtask : check_bus
  task automatic check_ctl();
    logic [7:0]  b0, b1, b2, b3;
    logic [15:0] e;
    b0 = shadow[0];
    b1 = shadow[1];
    b2 = shadow[2];
    b3 = shadow[3];
    e = {pg ? {b0[6], b0[5], b0[3], b0[1]} & ~gate_n : 4'h0,
         b1[5] ? b1[4:3] : b1[7:6], b1[1:0], b2[6], b2[5], b2[3], b2[1],
         b3[0], b3[5], b3[5] ? b3[4:3] : 2'h0};
    tally({run, loop_mode, amp, edge_spd, fb_spd, rate_en, rate} === e, e,
          {run, loop_mode, amp, edge_spd, fb_spd, rate_en, rate});
  endtask : check_ctl
  always @(cbsr_host_model_i.seen_ev)
  begin
    if (exp_q.size() == 0)
      tally(1'b0, 16'h0000, {8'h00, cbsr_host_model_i.seen});
    else
      check_bus(exp_q.pop_front(), cbsr_host_model_i.seen);
  end
  task automatic tx(input logic [7:0] e, d);
    exp_q.push_back(e);
    cbsr_host_model_i.send(d);
  endtask : tx
  task automatic rx(input logic [7:0] e, input logic last);
    exp_q.push_back(e);
    cbsr_host_model_i.fetch(last);
  endtask : rx
  task automatic wr(input logic [6:0] a, input int n, x, extra);
    logic [7:0] d;
    logic       hit;
    hit = (a === dev_addr) && ce;
    cbsr_host_model_i.start();
    tx({7'h00, hit}, {a, 1'b0});
    tx({7'h00, hit}, n[7:0]);
    tx({7'h00, hit}, x[7:0]);
    for (int k = 0; k < x + extra; k++)
    begin
      d = 8'($urandom);
      if (n + k == 1)
        d[5] = rnd[0];
      if (n + k == 3)
        d[5] = rnd[1];
      if (n + k == 7)
        d = 8'h03;
      tx({7'h00, hit && k < x}, d);
      if (hit && k < x && n + k < 8)
        shadow[n+k] = (shadow[n+k] & ~wmask[n+k]) | (d & wmask[n+k]);
    end
    cbsr_host_model_i.stop();
    cbsr_host_model_i.hold(8);
  endtask : wr
  task automatic rd(input int n);
    int len;
    len = int'(shadow[7][4:0]);
    cbsr_host_model_i.start();
    tx(8'h01, {dev_addr, 1'b0});
    tx(8'h01, n[7:0]);
    cbsr_host_model_i.start();
    tx(8'h01, {dev_addr, 1'b1});
    rx({3'h0, shadow[7][4:0]}, 1'b0);
    for (int k = 0; k < len; k++)
      rx(n + k < 8 ? shadow[n+k] : 8'h00, k == len - 1);
    cbsr_host_model_i.stop();
  endtask : rd
  initial
  begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  initial
  begin
    repeat (90000) @(posedge mclk_in);
    n_fail++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(89557));
    reset_n_in = 1'b0;
    ce = 1'b1;
    pg = 1'b0;
    rnd = 2'h0;
    addr_strap = 2'($urandom_range(2));
    mode_strap = 2'($urandom);
    gate_n = 4'($urandom);
    dev_addr = addr_strap == 2'h0 ? 7'h6B : addr_strap == 2'h1 ? 7'h6C
             : 7'h6D;
    shadow = '{8'hFF, {mode_strap, 6'h06}, 8'hFF, 8'hC7, 8'hFF, 8'h25,
               8'h8A, 8'h08};
    repeat (16) @(posedge mclk_in);
    @(negedge mclk_in);
    reset_n_in = 1'b1;
    cbsr_host_model_i.hold(8);
    pg = 1'b1;
    cbsr_host_model_i.hold(12);
    check_ctl();
    wr({dev_addr[6:1], ~dev_addr[0]}, 0, 1, 0);
    rd(0);
    $display("TB: reset and identity test done");
    for (int r = 0; r < 4; r++)
    begin
      rnd = 2'(r);
      gate_n = 4'($urandom);
      wr(dev_addr, 0, 4, 1);
      check_ctl();
      rd(0);
      $display("TB: write round %0d done", r);
    end
    ce = 1'b0;
    wr(dev_addr, 0, 1, 0);
    ce = 1'b1;
    wr(dev_addr, 4, 4, 0);
    rd(6);
    $display("TB: length and index end test done");
    pg = 1'b0;
    mode_strap = ~mode_strap;
    cbsr_host_model_i.hold(8);
    check_ctl();
    pg = 1'b1;
    cbsr_host_model_i.hold(12);
    shadow[1][7:6] = mode_strap;
    check_ctl();
    rd(0);
    $display("TB: power cycle test done");
    wrap_up();
  end
endmodule : cbsr_top_tb
`default_nettype wire
